/* rtl/scsi_seq_pkg.sv */
// shared constants and types for the initiator handshake sequencer
package scsi_seq_pkg;

  // byte-wide bus, one data byte per handshake
  localparam int PORT_W = 8;

  // i/o addresses of the three ports and the mode word
  localparam logic [7:0] BUS_DATA_PORT_ADDR = 8'hC8;
  localparam logic [7:0] BUS_STATUS_PORT_ADDR = 8'hCA;
  localparam logic [7:0] BUS_CONTROL_PORT_ADDR = 8'hCC;
  localparam logic [7:0] MODE_WORD_ADDR = 8'hCE;

  // control port fields
  localparam int CTL_SEL_BIT = 1;
  localparam int CTL_ATN_BIT = 2;
  localparam int CTL_DISABLE_BIT = 6;
  // disable bit high after reset, like the pulled-up line
  localparam logic [7:0] CTL_RESET = 8'h40;

  // write data bit that steers status-port and mode-word writes
  localparam int IO_DATA_BIT_FOUR = 4;

  // status port fields
  localparam int STS_SEL_BIT = 0;
  localparam int STS_BSY_BIT = 1;
  localparam int STS_DC_BIT = 2;
  localparam int STS_OI_BIT = 3;
  localparam int STS_MSG_BIT = 4;
  localparam int STS_REQ_BIT = 5;
  localparam int STS_RST_BIT = 6;
  localparam int STS_BAD_PARITY_BIT = 7;

  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // sequencer states, one-hot
  typedef enum logic [9:0] {
    SEQ_IDLE      = 10'h001,
    SEQ_WR1       = 10'h002,
    SEQ_WR2       = 10'h004,
    SEQ_WR3       = 10'h008,
    SEQ_WR_ACKSET = 10'h010,
    SEQ_WR5       = 10'h020,
    SEQ_WR6       = 10'h040,
    SEQ_RD_ACKSET = 10'h080,
    SEQ_HOLD      = 10'h100,
    SEQ_HOLD_EXIT = 10'h200
  } seq_state_t;

  // processor i/o cycle as seen by the ports
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic io_write_strobe_n;
    logic io_read_strobe_n;
    logic t3_second_phase;
  } io_req_t;

  // target-driven bus control lines, raw active-low levels
  typedef struct packed {
    logic req_n;
    logic dc_n;
    logic oi_n;
    logic msg_n;
    logic bsy_n;
    logic sel_n;
    logic rst_n;
  } scsi_in_t;

  // whole state of the sequencer
  typedef struct packed {
    seq_state_t seq;
    logic ack_enable_latch;
    logic bad_parity;
    logic port_input_flag_n;
    logic [7:0] data_port;
    logic [7:0] ctl_port;
    logic [7:0] rdata;
    logic ack_n;
  } core_state_t;

endpackage

/* rtl/odd_parity_unit.sv */
// odd parity generator and checker for one bus byte
`timescale 1ns/1ns
module odd_parity_unit #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] data,
  input wire logic par_in,
  output logic par_gen,
  output logic par_bad
);

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("odd_parity_unit needs at least one data bit");
    end
  endgenerate

  // generated bit makes the count of ones odd
  assign par_gen = ~^data;
  // received byte plus parity must hold an odd count of ones
  assign par_bad = ~^{data, par_in};

endmodule

/* rtl/scsi_initiator_handshake_sequencer.sv */
// initiator-side REQ/ACK sequencer behind data, status and control ports
//
// Operation
// RL1: data write phase: target holds data/command, out/in, message deasserted.
// RL2: DMA request when REQ asserted with data/command deasserted.
// RL3: write path starts on data port write in T3 second phase.
// RL4: DMA request drops as soon as the i/o write strobe goes low.
// RL5: write path: three states, ACK enable state, two states, idle with ACK.
// RL6: once started, one state step per processor clock edge.
// RL7: in data read the target sets up stable data before REQ.
// RL8: data port read with out/in asserted jumps to ACK enable state.
// RL9: in data read the DMA request ends when leaving idle.
// RL10: status phase uses the read path, no DMA request.
// RL11: message read uses the read path, no DMA request, one phase.
// RL12: message write only after attention; uses the write path.
// RL13: software asserts attention through control port bit 2.
// RL14: interrupt whenever REQ and data/command are both asserted.
// RL15: status port write with bit 4 low enters the hold state.
// RL16: hold state arms interrupt on any REQ, data phases included.
// RL17: status port read in hold clears bad parity and returns idle.
// RL18: bad-parity latch set on wrong odd parity in read phases; bit 7.
// RL19: status port write with bit 4 high in idle clears bad parity.
// RL20: odd parity driven on every write; generation leaves latch alone.
// RL21: no arbitration and no reselection logic.
// RL22: software enables the port by clearing control bit 6.
// RL23: one REQ/ACK handshake per byte, ACK held until REQ drops.
// RL24: transceiver on for port input or bus output; direction from out/in.
// RL25: control bit 6 high forces the sequencer to idle.
// RL26: after reset DMA request, interrupt, ACK and ACK enable are off.
`timescale 1ns/1ns
module scsi_initiator_handshake_sequencer (
  input wire logic core_clk,
  input wire logic nrst,
  input wire scsi_seq_pkg::io_req_t io_req,
  output logic [7:0] io_rdata,
  input wire scsi_seq_pkg::scsi_in_t scsi_in,
  input wire logic [scsi_seq_pkg::PORT_W-1:0] db_in,
  output logic [scsi_seq_pkg::PORT_W-1:0] db_out,
  output logic db_oe,
  input wire logic parity_in,
  output logic parity_drive_a,
  output logic parity_drive_b,
  output logic parity_oe,
  output logic ack_n,
  output logic atn_n,
  output logic sel_n,
  output logic dma_request,
  output logic scsi_interrupt,
  output logic transceiver_enable_n,
  output logic transceiver_direction
);

  scsi_seq_pkg::core_state_t state_r;
  scsi_seq_pkg::core_state_t state_nxt;

  logic enabled;
  logic io_wr;
  logic io_rd;
  logic data_wr;
  logic data_wr_t3;
  logic data_rd;
  logic status_wr;
  logic status_rd;
  logic ctl_wr;
  logic mode_wr;
  logic req;
  logic dc_asserted;
  logic oi_asserted;
  logic bit_four;
  logic in_idle;
  logic in_hold;
  logic par_gen;
  logic par_bad;
  logic set_bad_parity;
  logic clr_bad_parity;
  logic enter_ack_set;
  logic [7:0] status_word;

  // parity for the byte driven out and for the byte coming in
  odd_parity_unit #(
    .WIDTH(scsi_seq_pkg::PORT_W)
  ) u_gen_parity (
    .data(state_r.data_port),
    .par_in(1'b0),
    .par_gen(par_gen),
    .par_bad()
  );

  odd_parity_unit #(
    .WIDTH(scsi_seq_pkg::PORT_W)
  ) u_chk_parity (
    .data(db_in),
    .par_in(parity_in),
    .par_gen(),
    .par_bad(par_bad)
  );

  // every port write repeats while its strobe stays low, harmless for
  // the level registers; the sequencer only ever starts from idle
  // port decode; strobes are active low
  assign io_wr = !io_req.io_write_strobe_n;
  assign io_rd = !io_req.io_read_strobe_n;
  assign data_wr = io_wr && (io_req.addr == scsi_seq_pkg::BUS_DATA_PORT_ADDR);
  assign data_wr_t3 = data_wr && io_req.t3_second_phase; // RL3
  assign data_rd = io_rd && (io_req.addr == scsi_seq_pkg::BUS_DATA_PORT_ADDR);
  assign status_wr = io_wr &&
    (io_req.addr == scsi_seq_pkg::BUS_STATUS_PORT_ADDR);
  assign status_rd = io_rd &&
    (io_req.addr == scsi_seq_pkg::BUS_STATUS_PORT_ADDR);
  assign ctl_wr = io_wr &&
    (io_req.addr == scsi_seq_pkg::BUS_CONTROL_PORT_ADDR);
  assign mode_wr = io_wr && (io_req.addr == scsi_seq_pkg::MODE_WORD_ADDR);
  assign bit_four = io_req.wdata[scsi_seq_pkg::IO_DATA_BIT_FOUR];

  // bus lines in asserted-high form
  assign req = !scsi_in.req_n;
  assign dc_asserted = !scsi_in.dc_n;
  assign oi_asserted = !scsi_in.oi_n;

  // enable is control bit 6 inverted, so the block wakes up disabled
  assign enabled = !state_r.ctl_port[scsi_seq_pkg::CTL_DISABLE_BIT]; // RL22
  assign in_idle = (state_r.seq == scsi_seq_pkg::SEQ_IDLE);
  assign in_hold = (state_r.seq == scsi_seq_pkg::SEQ_HOLD);

  // status word: raw bus levels plus the sticky parity error
  always_comb begin
    status_word = 8'h00;
    status_word[scsi_seq_pkg::STS_SEL_BIT] = scsi_in.sel_n;
    status_word[scsi_seq_pkg::STS_BSY_BIT] = scsi_in.bsy_n;
    status_word[scsi_seq_pkg::STS_DC_BIT] = scsi_in.dc_n;
    status_word[scsi_seq_pkg::STS_OI_BIT] = scsi_in.oi_n;
    status_word[scsi_seq_pkg::STS_MSG_BIT] = scsi_in.msg_n;
    status_word[scsi_seq_pkg::STS_REQ_BIT] = scsi_in.req_n;
    status_word[scsi_seq_pkg::STS_RST_BIT] = scsi_in.rst_n;
    status_word[scsi_seq_pkg::STS_BAD_PARITY_BIT] = state_r.bad_parity; // RL18
  end

  // parity latch events; read-path start is the only byte-in sample
  // point, since the target already holds stable data under REQ
  assign set_bad_parity = enabled && in_idle && data_rd && oi_asserted &&
    par_bad; // RL18 RL7
  assign clr_bad_parity =
    (in_idle && status_wr && bit_four) || // RL19
    (state_r.seq == scsi_seq_pkg::SEQ_HOLD_EXIT); // RL17

  // next-state logic for the whole block
  always_comb begin
    state_nxt = state_r;
    enter_ack_set = 1'b0;

    // sequencer walk, one step per clock once started
    case (state_r.seq)
      scsi_seq_pkg::SEQ_IDLE: begin
        if (data_wr_t3 && !oi_asserted) begin
          state_nxt.seq = scsi_seq_pkg::SEQ_WR1; // RL3 RL12 RL1
        end else if (data_rd && oi_asserted) begin
          state_nxt.seq = scsi_seq_pkg::SEQ_RD_ACKSET; // RL8 RL10 RL11
        end else if (status_wr && !bit_four) begin
          state_nxt.seq = scsi_seq_pkg::SEQ_HOLD; // RL15
        end
      end
      scsi_seq_pkg::SEQ_WR1: begin
        state_nxt.seq = scsi_seq_pkg::SEQ_WR2; // RL5 RL6
      end
      scsi_seq_pkg::SEQ_WR2: begin
        state_nxt.seq = scsi_seq_pkg::SEQ_WR3; // RL5 RL6
      end
      scsi_seq_pkg::SEQ_WR3: begin
        state_nxt.seq = scsi_seq_pkg::SEQ_WR_ACKSET; // RL5 RL6
      end
      scsi_seq_pkg::SEQ_WR_ACKSET: begin
        state_nxt.seq = scsi_seq_pkg::SEQ_WR5; // RL5 RL6
      end
      scsi_seq_pkg::SEQ_WR5: begin
        state_nxt.seq = scsi_seq_pkg::SEQ_WR6; // RL5 RL6
      end
      scsi_seq_pkg::SEQ_WR6: begin
        state_nxt.seq = scsi_seq_pkg::SEQ_IDLE; // RL5 RL6
      end
      scsi_seq_pkg::SEQ_RD_ACKSET: begin
        state_nxt.seq = scsi_seq_pkg::SEQ_IDLE; // RL8 RL6
      end
      scsi_seq_pkg::SEQ_HOLD: begin
        // the only state besides idle that waits on software
        if (status_rd) begin
          state_nxt.seq = scsi_seq_pkg::SEQ_HOLD_EXIT; // RL17
        end
      end
      scsi_seq_pkg::SEQ_HOLD_EXIT: begin
        state_nxt.seq = scsi_seq_pkg::SEQ_IDLE; // RL17
      end
      default: begin
        state_nxt.seq = scsi_seq_pkg::SEQ_IDLE;
      end
    endcase

    // disabled port pins the sequencer at idle
    if (!enabled) begin
      state_nxt.seq = scsi_seq_pkg::SEQ_IDLE; // RL25
    end

    // ACK enable: set in either ACK-set state, dropped when REQ goes
    enter_ack_set =
      (state_nxt.seq == scsi_seq_pkg::SEQ_WR_ACKSET) ||
      (state_nxt.seq == scsi_seq_pkg::SEQ_RD_ACKSET);
    if (!req || !enabled) begin
      state_nxt.ack_enable_latch = 1'b0; // RL23 RL26
    end else if (enter_ack_set) begin
      state_nxt.ack_enable_latch = 1'b1; // RL5 RL8
    end

    // ACK only shows once back at idle, so the delay states give the
    // driven byte time to settle on the cable first
    state_nxt.ack_n = !(state_nxt.ack_enable_latch && enabled &&
      (state_nxt.seq == scsi_seq_pkg::SEQ_IDLE)); // RL5 RL8 RL23

    // sticky parity error, a new error beats a same-cycle clear
    if (set_bad_parity) begin
      state_nxt.bad_parity = 1'b1; // RL18
    end else if (clr_bad_parity) begin
      state_nxt.bad_parity = 1'b0; // RL17 RL19
    end

    // port registers written from the processor
    if (data_wr) begin
      state_nxt.data_port = io_req.wdata;
    end
    if (ctl_wr) begin
      state_nxt.ctl_port = io_req.wdata; // RL13 RL22
    end
    if (mode_wr) begin
      state_nxt.port_input_flag_n = !bit_four; // RL24
    end

    // read data captured while the strobe is low; unmapped addresses
    // read as zero rather than a stale byte
    if (io_rd) begin
      case (io_req.addr)
        scsi_seq_pkg::BUS_DATA_PORT_ADDR: begin
          state_nxt.rdata = db_in;
        end
        scsi_seq_pkg::BUS_STATUS_PORT_ADDR: begin
          state_nxt.rdata = status_word;
        end
        scsi_seq_pkg::BUS_CONTROL_PORT_ADDR: begin
          state_nxt.rdata = state_r.ctl_port;
        end
        default: begin
          state_nxt.rdata = scsi_seq_pkg::RDATA_UNMAPPED;
        end
      endcase
    end
  end

  // single state register, synchronous active-low reset
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_r.seq <= scsi_seq_pkg::SEQ_IDLE;
      state_r.ack_enable_latch <= 1'b0; // RL26
      state_r.bad_parity <= 1'b0;
      state_r.port_input_flag_n <= 1'b1;
      state_r.data_port <= scsi_seq_pkg::DATA_RESET;
      state_r.ctl_port <= scsi_seq_pkg::CTL_RESET; // RL25 RL26
      state_r.rdata <= scsi_seq_pkg::DATA_RESET;
      state_r.ack_n <= 1'b1; // RL26
    end else begin
      state_r <= state_nxt;
    end
  end

  // DMA request only in idle on a data-phase REQ; dropped at once by
  // the write strobe so one REQ never yields two transfers
  assign dma_request = enabled && in_idle && req && !dc_asserted &&
    !state_r.ack_enable_latch && !data_wr; // RL2 RL4 RL9 RL10 RL11

  // interrupt on command-type REQ, or any REQ while held
  assign scsi_interrupt = enabled && req &&
    (dc_asserted || in_hold); // RL14 RL16

  assign ack_n = state_r.ack_n;
  assign io_rdata = state_r.rdata;

  // control lines come straight from the control port
  assign atn_n = !(enabled && state_r.ctl_port[scsi_seq_pkg::CTL_ATN_BIT]);
  assign sel_n = !(enabled && state_r.ctl_port[scsi_seq_pkg::CTL_SEL_BIT]);

  // transceiver and bus drive; out/in deasserted means initiator drives
  assign transceiver_enable_n = !(enabled &&
    (!state_r.port_input_flag_n || !oi_asserted)); // RL24
  assign transceiver_direction = scsi_in.oi_n; // RL24
  assign db_out = state_r.data_port;
  assign db_oe = enabled && !oi_asserted && state_r.port_input_flag_n;

  // parity follows the driven byte on every write cycle and never
  // touches the error latch
  assign parity_drive_a = par_gen; // RL20
  assign parity_drive_b = par_gen; // RL20
  assign parity_oe = db_oe; // RL20

  // no arbitration or reselection: selection is plain software on
  // the control port, and the sequencer never leaves idle for it
  // RL21

endmodule

/* bench/scsi_seq_properties.sv */
// port-level assertions for the initiator handshake sequencer
`timescale 1ns/1ns
module scsi_seq_properties (
  input wire logic core_clk,
  input wire logic nrst,
  input wire scsi_seq_pkg::io_req_t io_req,
  input wire scsi_seq_pkg::scsi_in_t scsi_in,
  input wire logic [7:0] db_out,
  input wire logic db_oe,
  input wire logic parity_drive_a,
  input wire logic parity_drive_b,
  input wire logic parity_oe,
  input wire logic ack_n,
  input wire logic dma_request,
  input wire logic scsi_interrupt,
  input wire logic transceiver_enable_n,
  input wire logic transceiver_direction
);
  logic wr_take;
  logic rd_take;
  // data-port strobes; idle and enable are left to the bench to arrange
  assign wr_take = !io_req.io_write_strobe_n && io_req.t3_second_phase &&
    io_req.addr == scsi_seq_pkg::BUS_DATA_PORT_ADDR;
  assign rd_take = !io_req.io_read_strobe_n &&
    io_req.addr == scsi_seq_pkg::BUS_DATA_PORT_ADDR;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  dma_phase_a: assert property (
    dma_request |-> !scsi_in.req_n && scsi_in.dc_n
  ) else $error("dma request outside a data phase");
  dma_wr_drop_a: assert property (
    !io_req.io_write_strobe_n &&
    io_req.addr == scsi_seq_pkg::BUS_DATA_PORT_ADDR |-> !dma_request
  ) else $error("dma request kept during data port write");
  int_cause_a: assert property (
    scsi_interrupt |-> !scsi_in.req_n && !dma_request
  ) else $error("interrupt without request or beside dma");
  wr_ack_lat_a: assert property (
    $fell(ack_n) && scsi_in.oi_n |-> $past(wr_take, 7) && !scsi_in.req_n
  ) else $error("write path ack not seven edges after start");
  rd_ack_lat_a: assert property (
    $fell(ack_n) && !scsi_in.oi_n |-> $past(rd_take, 2) && !scsi_in.req_n
  ) else $error("read path ack not two edges after start");
  ack_hold_a: assert property (
    !ack_n && !scsi_in.req_n |=> !ack_n
  ) else $error("ack dropped while request held");
  ack_release_a: assert property (
    $rose(scsi_in.req_n) |-> ##[1:2] ack_n
  ) else $error("ack not released after request dropped");
  parity_gen_a: assert property (
    parity_oe |-> parity_drive_a == ~^db_out && parity_drive_b == parity_drive_a
  ) else $error("bus parity not odd");
  xcvr_a: assert property (
    transceiver_direction == scsi_in.oi_n && (!db_oe || !transceiver_enable_n)
  ) else $error("transceiver control wrong");
endmodule

bind scsi_initiator_handshake_sequencer scsi_seq_properties i_props (
  .core_clk(core_clk), .nrst(nrst), .io_req(io_req), .scsi_in(scsi_in),
  .db_out(db_out), .db_oe(db_oe), .parity_drive_a(parity_drive_a),
  .parity_drive_b(parity_drive_b), .parity_oe(parity_oe), .ack_n(ack_n),
  .dma_request(dma_request), .scsi_interrupt(scsi_interrupt),
  .transceiver_enable_n(transceiver_enable_n),
  .transceiver_direction(transceiver_direction));

/* bench/scsi_target_model.sv */
// behavioural target that answers one byte per request
`timescale 1ns/1ns
module scsi_target_model (
  input wire logic core_clk,
  input wire logic ack_n,
  input wire logic [7:0] db_out,
  input wire logic [2:0] phase,
  input wire logic [7:0] byte_in,
  input wire logic bad_par,
  input wire logic go,
  output scsi_seq_pkg::scsi_in_t scsi_in,
  output logic [7:0] db_in,
  output logic parity_in,
  output logic [7:0] got,
  output logic busy
);
  // selected and quiet: busy held, no request; one process drives all
  initial begin
    scsi_in = 7'h7B;
    db_in = 8'hA5;
    parity_in = 1'b0;
    got = 8'h00;
    busy = 1'b0;
    // one handshake per go; reads wait longer to act as a slow target
    forever begin
      @(posedge core_clk iff go);
      busy = 1'b1;
      #1 {scsi_in.msg_n, scsi_in.dc_n, scsi_in.oi_n} = ~phase;
      db_in = phase[0] ? byte_in : ~db_in;
      parity_in = ~^db_in ^ bad_par;
      repeat (phase[0] ? 6 : 1) @(posedge core_clk);
      #1 scsi_in.req_n = 1'b0;
      @(posedge core_clk iff !ack_n);
      got = db_out;
      #1 scsi_in.req_n = 1'b1;
      @(posedge core_clk iff ack_n);
      // released lines must not keep the old byte
      #1 db_in = ~db_in;
      parity_in = ~parity_in;
      busy = 1'b0;
    end
  end
endmodule

/* bench/tb.sv */
// self-checking bench for the initiator handshake sequencer
`timescale 1ns/1ns
module tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  scsi_seq_pkg::io_req_t io_req = '{8'h00, 8'h00, 1'b1, 1'b1, 1'b0};
  scsi_seq_pkg::scsi_in_t scsi_in;
  logic [7:0] io_rdata, db_in, db_out, got, r;
  logic [7:0] byte_v = 8'h00;
  logic db_oe, parity_in, par_a, par_oe, ack_n, atn_n, dma, irq, xen_n, busy;
  logic par_b, xdir, sel_n;
  logic [2:0] phase = 3'h0;
  logic go = 1'b0;
  logic bad_par = 1'b0;
  logic [2:0] wph [3] = '{3'h0, 3'h2, 3'h6};
  logic [2:0] rph [3] = '{3'h1, 3'h3, 3'h7};
  int fail_count = 0;
  int n_tests = 0;
  always #50 core_clk = ~core_clk;
  scsi_initiator_handshake_sequencer i_dut (.core_clk(core_clk), .nrst(nrst),
    .io_req(io_req), .io_rdata(io_rdata), .scsi_in(scsi_in), .db_in(db_in),
    .db_out(db_out), .db_oe(db_oe), .parity_in(parity_in),
    .parity_drive_a(par_a), .parity_drive_b(par_b), .parity_oe(par_oe),
    .ack_n(ack_n), .atn_n(atn_n), .sel_n(sel_n), .dma_request(dma),
    .scsi_interrupt(irq), .transceiver_enable_n(xen_n),
    .transceiver_direction(xdir));
  scsi_target_model i_tgt (.core_clk(core_clk), .ack_n(ack_n),
    .db_out(db_out), .phase(phase), .byte_in(byte_v), .bad_par(bad_par),
    .go(go), .scsi_in(scsi_in), .db_in(db_in), .parity_in(parity_in),
    .got(got), .busy(busy));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // port cycles: one edge per write, two per read, then one idle edge
  // so back-to-back calls never re-assert a strobe in the same step
  task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
    io_req = '{a, d, 1'b0, 1'b1, 1'b1};
    @(posedge core_clk);
    #1 io_req = '{a, d, 1'b1, 1'b1, 1'b0};
    @(posedge core_clk);
    #1;
  endtask
  task automatic io_rd(input logic [7:0] a, output logic [7:0] d);
    io_req = '{a, 8'h00, 1'b1, 1'b0, 1'b0};
    repeat (2) @(posedge core_clk);
    #1 d = io_rdata;
    io_req = '{a, 8'h00, 1'b1, 1'b1, 1'b0};
    @(posedge core_clk);
    #1;
  endtask
  task automatic start(input logic [2:0] ph, input logic [7:0] b);
    phase = ph;
    byte_v = b;
    go = 1'b1;
    @(posedge core_clk);
    #1 go = 1'b0;
  endtask
  task automatic wait_req();
    for (int i = 0; i < 40 && scsi_in.req_n; i++) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 40 && busy; i++) @(posedge core_clk);
    #1;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    #1 nrst = 1'b1;
    chk({4'h0, ack_n, dma, irq, xen_n}, 8'h09);
    io_rd(8'hCC, r);
    chk(r, 8'h40);
    io_rd(8'h10, r);
    chk(r, 8'h00);
    io_wr(8'hCC, 8'h00);
    io_wr(8'hCC, 8'h02);
    chk({6'h0, sel_n, atn_n}, 8'h01);
    io_wr(8'hCC, 8'h04);
    chk({7'h0, atn_n}, 8'h00);
    chk({7'h0, sel_n}, 8'h01);
    io_wr(8'hCE, 8'h10);
    chk({6'h0, xen_n, db_oe}, 8'h00);
    io_wr(8'hCE, 8'h00);
    chk({6'h0, xen_n, db_oe}, 8'h01);
    $display("reset and port checks done");
    foreach (wph[i]) begin
      start(wph[i], {5'h15, wph[i]});
      wait_req();
      chk({6'h0, dma, irq}, {6'h0, wph[i] == 3'h0, wph[i][1]});
      io_wr(8'hC8, {5'h15, wph[i]});
      chk({7'h0, par_a}, {7'h0, ~^{5'h15, wph[i]}});
      chk({6'h0, par_b, xdir}, {6'h0, ~^{5'h15, wph[i]}, 1'b1});
      wait_done();
      chk(got, {5'h15, wph[i]});
      $display("write phase %0d done", wph[i]);
    end
    foreach (rph[i]) begin
      bad_par = (i == 2);
      start(rph[i], {5'h0A, rph[i]});
      wait_req();
      chk({6'h0, dma, irq}, {6'h0, rph[i] == 3'h1, rph[i][1]});
      io_rd(8'hCA, r);
      chk(r, {3'b010, ~rph[i][2], ~rph[i][0], ~rph[i][1], 2'b01});
      io_rd(8'hC8, r);
      chk(r, {5'h0A, rph[i]});
      chk({6'h0, xdir, db_oe}, 8'h00);
      chk({7'h0, dma}, 8'h00);
      wait_done();
      $display("read phase %0d done", rph[i]);
    end
    io_rd(8'hCA, r);
    chk({7'h0, r[7]}, 8'h01);
    io_wr(8'hCA, 8'h10);
    io_rd(8'hCA, r);
    chk({7'h0, r[7]}, 8'h00);
    $display("parity latch done");
    start(3'h1, 8'h5A);
    wait_req();
    io_rd(8'hC8, r);
    chk(r, 8'h5A);
    wait_done();
    bad_par = 1'b0;
    io_wr(8'hCA, 8'h00);
    start(3'h0, 8'hC3);
    wait_req();
    chk({6'h0, dma, irq}, 8'h01);
    io_rd(8'hCA, r);
    chk({7'h0, r[7]}, 8'h01);
    io_rd(8'hCA, r);
    chk({6'h0, r[7], dma}, 8'h01);
    io_wr(8'hC8, 8'hC3);
    wait_done();
    chk(got, 8'hC3);
    $display("hold loop done");
    conclude();
  end
  // run needs under 500 cycles; stop well past that
  initial begin
    #200000;
    fail_count++;
    conclude();
  end
endmodule
